// ===== core/scnv_regs.svh
`ifndef SCNV_REGS_SVH
`define SCNV_REGS_SVH

// Register indexes; the byte address is four times the index
`define SCNV_IDX_GATE 7'h47
`define SCNV_IDX_OPERAND 7'h48
`define SCNV_IDX_RESULT 7'h49
`define SCNV_IDX_SAVE 7'h4A
`define SCNV_IDX_INHIBIT 7'h4B
`define SCNV_IDX_TALLY_LO 7'h4D
`define SCNV_IDX_TALLY_HI 7'h4E

// Reset values
`define SCNV_RST_GATE 16'h0000
`define SCNV_RST_OPERAND 16'h0000
`define SCNV_RST_RESULT 16'h0000
`define SCNV_RST_SAVE 16'h0000
`define SCNV_RST_INHIBIT 16'h0000

// Field values
`define SCNV_GATE_OPEN 16'h0001
`define SCNV_INHIBIT_ON 16'h0001
`define SCNV_CMD_INIT_ALL 16'h0001
`define SCNV_CMD_CTRL 16'h0002
`define SCNV_CMD_INTYPE 16'h0004
`define SCNV_CMD_INRANGE 16'h0008
`define SCNV_CMD_PVRANGE 16'h0010
`define SCNV_RESULT_OK 16'h0000
`define SCNV_RESULT_INVALID 16'h8001
`define SCNV_SAVE_CODE 16'h5752
`define SCNV_TALLY_MAX 32'h000186A0

`endif

// ===== core/scnv_pkg.sv
package scnv_pkg;

    typedef enum logic [0:0] {
        SCNV_CMD_IDLE = 1'b0,
        SCNV_CMD_EXEC = 1'b1
    } scnv_cmd_state_t;

    typedef enum logic [0:0] {
        SCNV_NV_IDLE = 1'b0,
        SCNV_NV_WRITE = 1'b1
    } scnv_nv_state_t;

    typedef enum logic [0:0] {
        SCNV_SRC_SP = 1'b0,
        SCNV_SRC_AUTO = 1'b1
    } scnv_nv_src_t;

endpackage

// ===== core/scnv_nv_if.sv
`timescale 1ns/1ps
interface scnv_nv_if;
    logic start;
    scnv_pkg::scnv_nv_src_t src;
    logic busy;
    logic done;
    modport ctrl(output start, output src, input busy, input done);
    modport seq(input start, input src, output busy, output done);
endinterface

// ===== core/scnv_nv_seq.sv
`timescale 1ns/1ps
module scnv_nv_seq (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Controller side
    scnv_nv_if.seq nv,
    // Nonvolatile memory port
    output logic o_nv_req,
    output logic o_nv_sp,
    input wire logic i_nv_ack
);
    scnv_pkg::scnv_nv_state_t state;

    assign nv.busy = (state != scnv_pkg::SCNV_NV_IDLE);

    // One request per execution, whatever it covers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= scnv_pkg::SCNV_NV_IDLE;
            o_nv_req <= 1'b0;
            o_nv_sp <= 1'b0;
            nv.done <= 1'b0;
        end else begin
            nv.done <= 1'b0;
            case (state)
                scnv_pkg::SCNV_NV_IDLE: begin
                    if (nv.start) begin
                        o_nv_req <= 1'b1;
                        o_nv_sp <= (nv.src == scnv_pkg::SCNV_SRC_SP);
                        state <= scnv_pkg::SCNV_NV_WRITE;
                    end
                end
                default: begin
                    if (i_nv_ack) begin
                        o_nv_req <= 1'b0;
                        nv.done <= 1'b1;
                        state <= scnv_pkg::SCNV_NV_IDLE;
                    end
                end
            endcase
        end
    end

    property p_req_hold;
        @(posedge i_clk) disable iff (i_reset)
        o_nv_req && !i_nv_ack |=> o_nv_req && !nv.done;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("nv request dropped early");
endmodule

// ===== core/scnv_tally.sv
`timescale 1ns/1ps
`include "scnv_regs.svh"
module scnv_tally (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Count control
    input wire logic i_inc,
    input wire logic [31:0] i_init,
    // Count value
    output logic [31:0] o_tally
);
    logic loaded;

    // The kept count is taken one edge after reset release, never under reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            loaded <= 1'b0;
            o_tally <= 32'h00000000;
        end else if (!loaded) begin
            loaded <= 1'b1;
            o_tally <= (i_init > `SCNV_TALLY_MAX) ? `SCNV_TALLY_MAX : i_init;
        end else if (i_inc && o_tally < `SCNV_TALLY_MAX) begin
            o_tally <= o_tally + 32'h00000001;
        end
    end

    property p_sat;
        @(posedge i_clk) disable iff (i_reset)
        loaded && i_inc && o_tally == `SCNV_TALLY_MAX |=> o_tally == `SCNV_TALLY_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("tally passed its maximum");

    property p_inc;
        @(posedge i_clk) disable iff (i_reset)
        loaded && i_inc && o_tally < `SCNV_TALLY_MAX |=> o_tally == $past(o_tally) + 32'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("tally missed an execution");
endmodule

// ===== core/scnv_top.sv
// Summary of operation
// - Command gate: 0 blocks setup commands, 1 permits them; resets to 0.
// - Result reads 0 on success, error position, or -32767 if gated.
// - Code 1 returns parameters to factory default, except input type and frequency set by switches.
// - Code 2 applies controller parameters, reinitialises I/O and operation.
// - Code 4 applies input type, reinitialises ranges and operation.
// - Code 8 applies input range, reinitialises process value range, operation.
// - Code 16 applies process value range, reinitialises operation.
// - Factory restore keeps input type and frequency set by switches.
// - Unrecognised operand codes change nothing in module operation.
// - Operand clears to 0 when a setup command finishes.
// - Writing WR to save trigger starts a set point save; reads 0 otherwise.
// - Backup inhibit 0 enables, 1 disables automatic backup; resets to 0.
// - With backup enabled, each stored parameter update is written to memory.
// - Tally counts executions, saturates at 100,000; writes still happen.
// - Tally reads as one long word at positions 77 and 78.
// - Tally counts whole executions, not individual positions.
// - Inhibit is never saved and returns to 0 at power up.
// - New controller parameters take effect only after their command.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "scnv_regs.svh"
module scnv_top (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [31:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Setup command port to the parameter logic
    output logic O_CMD_REQ,
    output logic [4:0] O_CMD_SEL,
    output logic O_CMD_SW_INPUT_KEEP,
    output logic O_CMD_SW_FREQ_KEEP,
    input wire logic I_CMD_DONE,
    input wire logic I_CMD_ERR,
    input wire logic [15:0] I_CMD_ERR_POS,
    input wire logic I_SW_INPUT_SET,
    input wire logic I_SW_FREQ_SET,
    // Backup port
    input wire logic I_PARAM_STORED_UPD,
    output logic O_NV_REQ,
    output logic O_NV_SP,
    input wire logic I_NV_ACK,
    output logic [31:0] O_NV_TALLY,
    input wire logic [31:0] I_NV_TALLY_INIT
);
    scnv_nv_if nv();

    scnv_pkg::scnv_cmd_state_t cmd_state;
    logic [15:0] command_gate;
    logic [15:0] command_operand;
    logic [15:0] command_result;
    logic [15:0] setpoint_save_trigger;
    logic [15:0] backup_inhibit;
    logic [31:0] nv_write_tally;
    logic pend_sp;
    logic pend_auto;
    logic wb_req;
    logic wb_wr;
    logic [15:0] wr_val;

    function automatic logic is_reg(input logic [31:0] a, input logic [6:0] idx);
        return (a[31:9] == 23'h000000) && (a[8:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic is_cmd(input logic [15:0] v);
        return v == `SCNV_CMD_INIT_ALL || v == `SCNV_CMD_CTRL || v == `SCNV_CMD_INTYPE ||
               v == `SCNV_CMD_INRANGE || v == `SCNV_CMD_PVRANGE;
    endfunction

    // Ack comes one cycle after the request; a write lands on the acked edge
    assign wb_req = I_WB_CYC && I_WB_STB;
    assign wb_wr = wb_req && I_WB_WE && O_WB_ACK;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_WB_ACK <= 1'b0;
        end else begin
            O_WB_ACK <= wb_req && !O_WB_ACK;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_WB_DAT <= 32'h00000000;
        end else if (wb_req && !O_WB_ACK) begin
            if (is_reg(I_WB_ADR, `SCNV_IDX_GATE)) begin
                O_WB_DAT <= {16'h0000, command_gate};
            end else if (is_reg(I_WB_ADR, `SCNV_IDX_OPERAND)) begin
                O_WB_DAT <= {16'h0000, command_operand};
            end else if (is_reg(I_WB_ADR, `SCNV_IDX_RESULT)) begin
                O_WB_DAT <= {16'h0000, command_result};
            end else if (is_reg(I_WB_ADR, `SCNV_IDX_SAVE)) begin
                O_WB_DAT <= {16'h0000, setpoint_save_trigger};
            end else if (is_reg(I_WB_ADR, `SCNV_IDX_INHIBIT)) begin
                O_WB_DAT <= {16'h0000, backup_inhibit};
            end else if (is_reg(I_WB_ADR, `SCNV_IDX_TALLY_LO)) begin
                O_WB_DAT <= {16'h0000, nv_write_tally[15:0]};
            end else if (is_reg(I_WB_ADR, `SCNV_IDX_TALLY_HI)) begin
                O_WB_DAT <= {16'h0000, nv_write_tally[31:16]};
            end else begin
                O_WB_DAT <= 32'h00000000;
            end
        end
    end

    always_comb begin
        wr_val = 16'h0000;
        if (is_reg(I_WB_ADR, `SCNV_IDX_GATE)) begin
            wr_val = merge(command_gate, I_WB_DAT, I_WB_SEL);
        end else if (is_reg(I_WB_ADR, `SCNV_IDX_OPERAND)) begin
            wr_val = merge(command_operand, I_WB_DAT, I_WB_SEL);
        end else if (is_reg(I_WB_ADR, `SCNV_IDX_SAVE)) begin
            wr_val = merge(setpoint_save_trigger, I_WB_DAT, I_WB_SEL);
        end else if (is_reg(I_WB_ADR, `SCNV_IDX_INHIBIT)) begin
            wr_val = merge(backup_inhibit, I_WB_DAT, I_WB_SEL);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            command_gate <= `SCNV_RST_GATE;
        end else if (wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_GATE)) begin
            command_gate <= wr_val;
        end
    end

    // Inhibit lives only in flops, so power up always brings it back to 0
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            backup_inhibit <= `SCNV_RST_INHIBIT;
        end else if (wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_INHIBIT)) begin
            backup_inhibit <= wr_val;
        end
    end

    // Operand writes during a running command are dropped to keep the code stable
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cmd_state <= scnv_pkg::SCNV_CMD_IDLE;
            command_operand <= `SCNV_RST_OPERAND;
            command_result <= `SCNV_RST_RESULT;
            O_CMD_REQ <= 1'b0;
            O_CMD_SEL <= 5'h00;
            O_CMD_SW_INPUT_KEEP <= 1'b0;
            O_CMD_SW_FREQ_KEEP <= 1'b0;
        end else begin
            case (cmd_state)
                scnv_pkg::SCNV_CMD_IDLE: begin
                    if (wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_OPERAND)) begin
                        command_operand <= wr_val;
                        if (is_cmd(wr_val)) begin
                            if (command_gate != `SCNV_GATE_OPEN) begin
                                command_result <= `SCNV_RESULT_INVALID;
                                command_operand <= 16'h0000;
                            end else begin
                                // Selects code 1, 2, 4, 8 or 16 on the one-hot lines
                                O_CMD_REQ <= 1'b1;
                                O_CMD_SEL <= wr_val[4:0];
                                O_CMD_SW_INPUT_KEEP <= (wr_val == `SCNV_CMD_INIT_ALL) &&
                                                       I_SW_INPUT_SET;
                                O_CMD_SW_FREQ_KEEP <= (wr_val == `SCNV_CMD_INIT_ALL) &&
                                                      I_SW_FREQ_SET;
                                cmd_state <= scnv_pkg::SCNV_CMD_EXEC;
                            end
                        end
                    end
                end
                default: begin
                    if (I_CMD_DONE) begin
                        O_CMD_REQ <= 1'b0;
                        O_CMD_SEL <= 5'h00;
                        O_CMD_SW_INPUT_KEEP <= 1'b0;
                        O_CMD_SW_FREQ_KEEP <= 1'b0;
                        command_operand <= 16'h0000;
                        command_result <= I_CMD_ERR ? I_CMD_ERR_POS : `SCNV_RESULT_OK;
                        cmd_state <= scnv_pkg::SCNV_CMD_IDLE;
                    end
                end
            endcase
        end
    end

    // Only the code WR starts a save; anything else, zero included, is ignored
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            setpoint_save_trigger <= `SCNV_RST_SAVE;
        end else if (wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_SAVE) &&
                     wr_val == `SCNV_SAVE_CODE) begin
            setpoint_save_trigger <= `SCNV_SAVE_CODE;
        end else if (nv.done && !pend_sp && O_NV_SP) begin
            // The sequencer still shows the source of the execution that just ended
            setpoint_save_trigger <= 16'h0000;
        end
    end

    // A new request in the cycle a pending flag is taken keeps the flag set
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            pend_sp <= 1'b0;
        end else if (wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_SAVE) &&
                     wr_val == `SCNV_SAVE_CODE) begin
            pend_sp <= 1'b1;
        end else if (nv.start && nv.src == scnv_pkg::SCNV_SRC_SP) begin
            pend_sp <= 1'b0;
        end
    end

    // Updates that arrive during a write fold into the next execution
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            pend_auto <= 1'b0;
        end else if (I_PARAM_STORED_UPD && backup_inhibit != `SCNV_INHIBIT_ON) begin
            pend_auto <= 1'b1;
        end else if (nv.start && nv.src == scnv_pkg::SCNV_SRC_AUTO) begin
            pend_auto <= 1'b0;
        end
    end

    // Set point saves win over automatic backup
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            nv.start <= 1'b0;
            nv.src <= scnv_pkg::SCNV_SRC_SP;
        end else begin
            nv.start <= 1'b0;
            if (!nv.busy && !nv.start && (pend_sp || pend_auto)) begin
                nv.start <= 1'b1;
                nv.src <= pend_sp ? scnv_pkg::SCNV_SRC_SP : scnv_pkg::SCNV_SRC_AUTO;
            end
        end
    end

    scnv_nv_seq scnv_nv_seq_i (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .nv(nv.seq),
        .o_nv_req(O_NV_REQ),
        .o_nv_sp(O_NV_SP),
        .i_nv_ack(I_NV_ACK)
    );

    scnv_tally scnv_tally_i (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_inc(nv.done),
        .i_init(I_NV_TALLY_INIT),
        .o_tally(nv_write_tally)
    );

    assign O_NV_TALLY = nv_write_tally;

    sequence s_op_write;
        wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_OPERAND) && cmd_state == scnv_pkg::SCNV_CMD_IDLE;
    endsequence

    property p_ack_once;
        @(posedge I_CLK) disable iff (I_RESET)
        wb_req && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus ack not a single pulse");

    property p_gated;
        @(posedge I_CLK) disable iff (I_RESET)
        s_op_write and (is_cmd(wr_val) && command_gate != `SCNV_GATE_OPEN) |=>
            command_result == `SCNV_RESULT_INVALID && command_operand == 16'h0000 && !O_CMD_REQ;
    endproperty
    a_gated: assert property (p_gated) else $error("gated command not rejected");

    property p_exec;
        @(posedge I_CLK) disable iff (I_RESET)
        s_op_write and (is_cmd(wr_val) && command_gate == `SCNV_GATE_OPEN) |=>
            O_CMD_REQ && O_CMD_SEL == $past(wr_val[4:0]);
    endproperty
    a_exec: assert property (p_exec) else $error("permitted command not issued");

    property p_unrec;
        @(posedge I_CLK) disable iff (I_RESET)
        s_op_write and !is_cmd(wr_val) |=> !O_CMD_REQ && command_operand == $past(wr_val);
    endproperty
    a_unrec: assert property (p_unrec) else $error("unknown code acted on");

    property p_finish;
        @(posedge I_CLK) disable iff (I_RESET)
        O_CMD_REQ && I_CMD_DONE |=> !O_CMD_REQ && command_operand == 16'h0000 &&
            command_result == ($past(I_CMD_ERR) ? $past(I_CMD_ERR_POS) : `SCNV_RESULT_OK);
    endproperty
    a_finish: assert property (p_finish) else $error("command finish wrong");

    property p_inhibit;
        @(posedge I_CLK) disable iff (I_RESET)
        !pend_auto && backup_inhibit == `SCNV_INHIBIT_ON |=> !pend_auto;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("backup ran while inhibited");

    property p_auto_start;
        @(posedge I_CLK) disable iff (I_RESET)
        I_PARAM_STORED_UPD && backup_inhibit == 16'h0000 && !nv.busy && !pend_sp &&
            !pend_auto && !nv.start |=> ##1 nv.start;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("backup not started");

    property p_save_read;
        @(posedge I_CLK) disable iff (I_RESET)
        setpoint_save_trigger != 16'h0000 |-> setpoint_save_trigger == `SCNV_SAVE_CODE;
    endproperty
    a_save_read: assert property (p_save_read) else $error("save trigger odd value");

    property p_save_done;
        @(posedge I_CLK) disable iff (I_RESET)
        nv.done && O_NV_SP && !pend_sp && !wb_wr |=> setpoint_save_trigger == 16'h0000;
    endproperty
    a_save_done: assert property (p_save_done) else $error("save trigger not cleared");

    property p_cmd_hold;
        @(posedge I_CLK) disable iff (I_RESET)
        O_CMD_REQ && !I_CMD_DONE |=> O_CMD_REQ && O_CMD_SEL == $past(O_CMD_SEL);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped early");

    property p_idle_sel;
        @(posedge I_CLK) disable iff (I_RESET)
        !O_CMD_REQ |-> O_CMD_SEL == 5'h00;
    endproperty
    a_idle_sel: assert property (p_idle_sel) else $error("code shown while idle");

    property p_result_ro;
        @(posedge I_CLK) disable iff (I_RESET)
        wb_wr && is_reg(I_WB_ADR, `SCNV_IDX_RESULT) && cmd_state == scnv_pkg::SCNV_CMD_IDLE |=>
            command_result == $past(command_result);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result written by bus");
endmodule

// ===== verification/test_scnv_top.sv
`timescale 1ns/1ps
`include "scnv_regs.svh"
module test_setup_command_and_nv_backup;
    logic I_CLK, I_RESET, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK;
    logic [31:0] I_WB_ADR, I_WB_DAT, O_WB_DAT, O_NV_TALLY, I_NV_TALLY_INIT;
    logic [3:0] I_WB_SEL;
    logic O_CMD_REQ, O_CMD_SW_INPUT_KEEP, O_CMD_SW_FREQ_KEEP, I_CMD_DONE, I_CMD_ERR;
    logic [4:0] O_CMD_SEL;
    logic [15:0] I_CMD_ERR_POS;
    logic I_SW_INPUT_SET, I_SW_FREQ_SET, I_PARAM_STORED_UPD, O_NV_REQ, O_NV_SP, I_NV_ACK;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    scnv_top scnv_top_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_WB_CYC(I_WB_CYC),
        .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
        .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_CMD_REQ(O_CMD_REQ),
        .O_CMD_SEL(O_CMD_SEL), .O_CMD_SW_INPUT_KEEP(O_CMD_SW_INPUT_KEEP),
        .O_CMD_SW_FREQ_KEEP(O_CMD_SW_FREQ_KEEP), .I_CMD_DONE(I_CMD_DONE),
        .I_CMD_ERR(I_CMD_ERR), .I_CMD_ERR_POS(I_CMD_ERR_POS), .I_SW_INPUT_SET(I_SW_INPUT_SET),
        .I_SW_FREQ_SET(I_SW_FREQ_SET), .I_PARAM_STORED_UPD(I_PARAM_STORED_UPD),
        .O_NV_REQ(O_NV_REQ), .O_NV_SP(O_NV_SP), .I_NV_ACK(I_NV_ACK),
        .O_NV_TALLY(O_NV_TALLY), .I_NV_TALLY_INIT(I_NV_TALLY_INIT));

    initial begin
        I_CLK = 0;
        forever #5 I_CLK = ~I_CLK;
    end

    task test_done();
        $display("checks=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; the ceiling leaves ample slack
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL reg t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_pin(input logic [4:0] got, input logic [4:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL pin t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: request held until the edge that samples ack high
    task wb(input logic we, input logic [6:0] idx, input logic [15:0] d, output logic [31:0] q);
        @(posedge I_CLK);
        I_WB_CYC <= 1'b1;
        I_WB_STB <= 1'b1;
        I_WB_WE <= we;
        I_WB_ADR <= {23'h000000, idx, 2'h0};
        I_WB_DAT <= {16'h0000, d};
        // Only the bench ceiling ends a wait for ack
        do begin
            @(posedge I_CLK);
        end while (O_WB_ACK !== 1'b1);
        q = O_WB_DAT;
        I_WB_CYC <= 1'b0;
        I_WB_STB <= 1'b0;
    endtask

    task wr(input logic [6:0] idx, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task rdc(input logic [6:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 16'h0000, q);
        chk_reg(q, exp);
    endtask

    task tally_chk(input logic [31:0] exp);
        logic [31:0] lo, hi;
        wb(1'b0, `SCNV_IDX_TALLY_LO, 16'h0000, lo);
        wb(1'b0, `SCNV_IDX_TALLY_HI, 16'h0000, hi);
        chk_reg({hi[15:0], lo[15:0]}, exp);
        chk_reg(O_NV_TALLY, exp);
    endtask

    task do_reset(input logic [31:0] init);
        @(posedge I_CLK);
        I_RESET <= 1'b1;
        I_NV_TALLY_INIT <= init;
        repeat (2) @(posedge I_CLK);
        I_RESET <= 1'b0;
        @(posedge I_CLK);
    endtask

    task pulse_upd();
        @(posedge I_CLK);
        I_PARAM_STORED_UPD <= 1'b1;
        @(posedge I_CLK);
        I_PARAM_STORED_UPD <= 1'b0;
    endtask

    // Far side stalls its ack; optional updates arrive while the write runs
    task nv_exec(input logic sp, input int stall, input logic merge);
        int n;
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_NV_REQ !== 1'b1 && n < 10);
        chk_pin(O_NV_REQ, 5'h01);
        chk_pin(O_NV_SP, sp);
        repeat (stall) begin
            I_PARAM_STORED_UPD <= merge;
            @(posedge I_CLK);
            chk_pin(O_NV_REQ, 5'h01);
        end
        I_PARAM_STORED_UPD <= 1'b0;
        I_NV_ACK <= 1'b1;
        @(posedge I_CLK);
        I_NV_ACK <= 1'b0;
        repeat (3) @(posedge I_CLK);
    endtask

    task no_nv();
        repeat (8) begin
            @(posedge I_CLK);
            chk_pin(O_NV_REQ, 5'h00);
        end
    endtask

    task test_regs();
        rdc(`SCNV_IDX_GATE, 32'h00000000);
        rdc(`SCNV_IDX_OPERAND, 32'h00000000);
        rdc(`SCNV_IDX_RESULT, 32'h00000000);
        rdc(`SCNV_IDX_SAVE, 32'h00000000);
        rdc(`SCNV_IDX_INHIBIT, 32'h00000000);
        rdc(7'h4C, 32'h00000000);
        tally_chk(32'h00000005);
        wr(`SCNV_IDX_RESULT, 16'h1234);
        rdc(`SCNV_IDX_RESULT, 32'h00000000);
        wr(`SCNV_IDX_GATE, 16'h0001);
        rdc(`SCNV_IDX_GATE, 32'h00000001);
        wr(`SCNV_IDX_INHIBIT, 16'h0001);
        rdc(`SCNV_IDX_INHIBIT, 32'h00000001);
        do_reset(32'h00000005);
        rdc(`SCNV_IDX_INHIBIT, 32'h00000000);
        rdc(`SCNV_IDX_GATE, 32'h00000000);
        $display("test_regs finished");
    endtask

    task test_gated();
        wr(`SCNV_IDX_OPERAND, 16'h0002);
        repeat (4) begin
            @(posedge I_CLK);
            chk_pin(O_CMD_REQ, 5'h00);
        end
        rdc(`SCNV_IDX_RESULT, 32'h00008001);
        rdc(`SCNV_IDX_OPERAND, 32'h00000000);
        $display("test_gated finished");
    endtask

    task test_cmds();
        logic [15:0] code;
        int n;
        wr(`SCNV_IDX_GATE, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            // The last pass repeats code 1 with only the frequency switch set
            code = (i == 5) ? 16'h0001 : (16'h0001 << i);
            I_SW_INPUT_SET <= (i != 5);
            I_SW_FREQ_SET <= (i == 5);
            wr(`SCNV_IDX_OPERAND, code);
            n = 0;
            do begin
                @(posedge I_CLK);
                n++;
            end while (O_CMD_REQ !== 1'b1 && n < 8);
            chk_pin(O_CMD_SEL, code[4:0]);
            chk_pin(O_CMD_SW_INPUT_KEEP, (i == 0) ? 5'h01 : 5'h00);
            chk_pin(O_CMD_SW_FREQ_KEEP, (i == 5) ? 5'h01 : 5'h00);
            repeat (3) begin
                @(posedge I_CLK);
                chk_pin(O_CMD_REQ, 5'h01);
            end
            I_CMD_DONE <= 1'b1;
            I_CMD_ERR <= (i == 3);
            I_CMD_ERR_POS <= 16'h0051;
            @(posedge I_CLK);
            I_CMD_DONE <= 1'b0;
            I_CMD_ERR <= 1'b0;
            rdc(`SCNV_IDX_OPERAND, 32'h00000000);
            rdc(`SCNV_IDX_RESULT, (i == 3) ? 32'h00000051 : 32'h00000000);
            chk_pin(O_CMD_REQ, 5'h00);
        end
        wr(`SCNV_IDX_OPERAND, 16'h0003);
        repeat (4) begin
            @(posedge I_CLK);
            chk_pin(O_CMD_REQ, 5'h00);
        end
        $display("test_cmds finished");
    endtask

    task test_save();
        wr(`SCNV_IDX_SAVE, 16'h1234);
        no_nv();
        wr(`SCNV_IDX_SAVE, 16'h5752);
        nv_exec(1'b1, 4, 1'b0);
        rdc(`SCNV_IDX_SAVE, 32'h00000000);
        tally_chk(32'h00000006);
        $display("test_save finished");
    endtask

    task test_auto();
        pulse_upd();
        nv_exec(1'b0, 3, 1'b1);
        nv_exec(1'b0, 0, 1'b0);
        tally_chk(32'h00000008);
        wr(`SCNV_IDX_INHIBIT, 16'h0001);
        pulse_upd();
        no_nv();
        tally_chk(32'h00000008);
        wr(`SCNV_IDX_INHIBIT, 16'h0000);
        $display("test_auto finished");
    endtask

    task test_sat();
        do_reset(32'h0001869F);
        tally_chk(32'h0001869F);
        pulse_upd();
        nv_exec(1'b0, 1, 1'b0);
        tally_chk(`SCNV_TALLY_MAX);
        wr(`SCNV_IDX_SAVE, 16'h5752);
        nv_exec(1'b1, 1, 1'b0);
        tally_chk(`SCNV_TALLY_MAX);
        do_reset(32'h00030D40);
        tally_chk(`SCNV_TALLY_MAX);
        $display("test_sat finished");
    endtask

    initial begin
        I_RESET = 1'b1;
        I_WB_CYC = 1'b0;
        I_WB_STB = 1'b0;
        I_WB_WE = 1'b0;
        I_WB_ADR = 32'h00000000;
        I_WB_SEL = 4'hF;
        I_WB_DAT = 32'h00000000;
        I_CMD_DONE = 1'b0;
        I_CMD_ERR = 1'b0;
        I_CMD_ERR_POS = 16'h0000;
        I_SW_INPUT_SET = 1'b0;
        I_SW_FREQ_SET = 1'b0;
        I_PARAM_STORED_UPD = 1'b0;
        I_NV_ACK = 1'b0;
        I_NV_TALLY_INIT = 32'h00000005;
        repeat (2) @(posedge I_CLK);
        I_RESET <= 1'b0;
        @(posedge I_CLK);
        test_regs();
        test_gated();
        test_cmds();
        test_save();
        test_auto();
        test_sat();
        test_done();
    end
endmodule
